/* File: common/aal_pkg.sv */
// shared constants, types and arithmetic helpers for the accumulator alu block
package aal_pkg;
    localparam int CLK_NS = 8;
    localparam int WDT_TICK_NS = 1000;
    localparam int WDT_TICK_CYC = (WDT_TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam logic [AXI_AW-1:0] A_CMD = 8'h00;
    localparam logic [AXI_AW-1:0] A_ACC = 8'h04;
    localparam logic [AXI_AW-1:0] A_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] A_FADDR = 8'h0C;
    localparam logic [AXI_AW-1:0] A_FDATA = 8'h10;
    localparam logic [AXI_AW-1:0] A_TBL = 8'h14;
    localparam logic [AXI_AW-1:0] A_PC = 8'h18;
    localparam logic [AXI_AW-1:0] A_WDT = 8'h1C;
    localparam logic [AXI_AW-1:0] A_WAKE = 8'h20;
    localparam int OP_W = 4;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 4;
    localparam int CMD_FA_LSB = 8;
    localparam int CMD_LIT_LSB = 16;
    localparam int TBL_IDX_LSB = 0;
    localparam int TBL_VAL_LSB = 8;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_TO = 3;
    localparam int ST_PWR = 4;
    localparam int ST_SLP = 5;
    localparam int ST_BUSY = 6;
    localparam int WDT_PRE_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] PC_STEP = 8'h01;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [OP_W-1:0] {
        OP_NOP, OP_ROTR, OP_ROTL, OP_SUBF, OP_SUBL, OP_SWAPN,
        OP_XORL, OP_XORF, OP_ADDF, OP_ADDPC, OP_SLEEP
    } aal_op_t;

    typedef enum logic [1:0] {ST_RUN, ST_TBL, ST_SLEEP} aal_state_t;

    // carry out of bit 7 lands in bit 8
    function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction : add9

    function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b,
                                        input logic cin);
        add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    endfunction : add5
endpackage : aal_pkg

/* File: src/aal_alu.sv */
// combinational result and flag generation for one instruction
`timescale 1ns/1ps
`default_nettype none
module aal_alu (
    input wire aal_pkg::aal_op_t op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] opnd_i,
    input wire logic c_i,
    output logic [7:0] res_o,
    output logic c_o,
    output logic dc_o,
    output logic z_o,
    output logic wr_o,
    output logic lit_o,
    output logic upd_c_o,
    output logic upd_dc_o,
    output logic upd_z_o
);
    import aal_pkg::*;
    logic [8:0] sub9, sum9;
    logic [4:0] sub5, sum5;

    // subtraction as opnd + ~acc + 1: carry high means no borrow
    assign sub9 = add9(opnd_i, ~acc_i, 1'b1);
    assign sub5 = add5(opnd_i[3:0], ~acc_i[3:0], 1'b1);
    assign sum9 = add9(opnd_i, acc_i, 1'b0);
    assign sum5 = add5(opnd_i[3:0], acc_i[3:0], 1'b0);

    always_comb begin
        res_o = opnd_i;
        c_o = c_i;
        dc_o = 1'b0;
        wr_o = 1'b1;
        lit_o = 1'b0;
        upd_c_o = 1'b0;
        upd_dc_o = 1'b0;
        upd_z_o = 1'b0;
        case (op_i)
            OP_ROTR: begin
                res_o = {c_i, opnd_i[7:1]}; // [RQ1]
                c_o = opnd_i[0];
                upd_c_o = 1'b1;
            end
            OP_ROTL: begin
                res_o = {opnd_i[6:0], c_i}; // [RQ2]
                c_o = opnd_i[7];
                upd_c_o = 1'b1;
            end
            OP_SUBF, OP_SUBL: begin
                res_o = sub9[7:0]; // [RQ4] [RQ6]
                c_o = sub9[8]; // [RQ5]
                dc_o = sub5[4];
                lit_o = (op_i == OP_SUBL);
                upd_c_o = 1'b1;
                upd_dc_o = 1'b1;
                upd_z_o = 1'b1;
            end
            OP_SWAPN: res_o = {opnd_i[3:0], opnd_i[7:4]}; // [RQ10]
            OP_XORL, OP_XORF: begin
                res_o = acc_i ^ opnd_i; // [RQ11] [RQ12]
                lit_o = (op_i == OP_XORL);
                upd_z_o = 1'b1;
            end
            OP_ADDF: begin
                res_o = sum9[7:0];
                c_o = sum9[8];
                dc_o = sum5[4];
                upd_c_o = 1'b1;
                upd_dc_o = 1'b1;
                upd_z_o = 1'b1;
            end
            default: wr_o = 1'b0;
        endcase
        z_o = (res_o == BYTE_ZERO); // [RQ14]
    end
endmodule : aal_alu
`default_nettype wire

/* File: src/aal_core.sv */
// accumulator alu execution unit with axi4-lite register access
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1: rotate right through carry: old carry to bit 7, bit 0 to carry.
// RQ2: rotate left through carry: old carry to bit 0, bit 7 to carry.
// RQ3: destination bit 0 writes accumulator, 1 writes the file register back.
// RQ4: subtract-from-file gives file minus accumulator to the chosen destination.
// RQ5: subtraction sets carry and nibble carry unless accumulator part is larger.
// RQ6: subtract-from-literal gives literal minus accumulator, always into accumulator.
// RQ7: sleep sets the watchdog-expired flag and clears the sleep-entered flag.
// RQ8: sleep clears the watchdog counter and its prescaler.
// RQ9: after sleep the core halts in its low-power state.
// RQ10: nibble exchange swaps the two nibbles, flags untouched.
// RQ11: xor-literal xors accumulator with literal into accumulator, only zero changes.
// RQ12: xor-file xors accumulator with file into destination, only zero changes.
// RQ13: adding accumulator to pc jumps into a constant table, then returns.
// RQ14: zero flag is set exactly when the 8-bit result is zero.
module aal_core #(
    parameter int FILE_DEPTH = 128,
    parameter int TBL_DEPTH = 16,
    parameter int WDT_TICK = aal_pkg::WDT_TICK_CYC
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic AXI_AWVALID_I,
    output logic AXI_AWREADY_O,
    input wire logic [aal_pkg::AXI_AW-1:0] AXI_AWADDR_I,
    input wire logic AXI_WVALID_I,
    output logic AXI_WREADY_O,
    input wire logic [aal_pkg::AXI_DW-1:0] AXI_WDATA_I,
    input wire logic [3:0] AXI_WSTRB_I,
    output logic AXI_BVALID_O,
    input wire logic AXI_BREADY_I,
    output logic [1:0] AXI_BRESP_O,
    input wire logic AXI_ARVALID_I,
    output logic AXI_ARREADY_O,
    input wire logic [aal_pkg::AXI_AW-1:0] AXI_ARADDR_I,
    output logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I,
    output logic [aal_pkg::AXI_DW-1:0] AXI_RDATA_O,
    output logic [1:0] AXI_RRESP_O,
    output logic SLEEP_O
);
    import aal_pkg::*;
    localparam int FA_W = $clog2(FILE_DEPTH);
    localparam int TB_W = $clog2(TBL_DEPTH);
    localparam int DIV_W = $clog2(WDT_TICK + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(WDT_TICK - 1);

    logic aw_have_q, w_have_q, lane0_q, bvalid_q, rvalid_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [AXI_DW-1:0] wdata_q, rdata_q;
    logic [1:0] bresp_q, rresp_q;
    logic go_q, dest_q;
    aal_op_t op_q;
    logic [FA_W-1:0] fa_q, swfa_q;
    logic [7:0] lit_q, acc_q, pc_q, ret_q, pre_q, wdt_q;
    logic c_q, dc_q, z_q, to_q, pwr_q;
    logic [7:0] file_q [FILE_DEPTH];
    logic [7:0] tbl_q [TBL_DEPTH];
    aal_state_t state_q;
    logic [DIV_W-1:0] div_q;
    logic wr_do, wr_en, ex, tick, wdt_ovf, wake, sleep_go;
    logic [7:0] fval, opnd, tbl_out, alu_res;
    logic alu_c, alu_dc, alu_z, alu_wr, alu_lit, upd_c, upd_dc, upd_z;
    logic to_acc, to_file;
    logic [AXI_DW-1:0] stat_w, cmd_w;

    function automatic logic mapped(input logic [AXI_AW-1:0] a);
        mapped = (a == A_CMD) || (a == A_ACC) || (a == A_STATUS) ||
                 (a == A_FADDR) || (a == A_FDATA) || (a == A_TBL) ||
                 (a == A_PC) || (a == A_WDT) || (a == A_WAKE);
    endfunction : mapped

    // ---- bus slave: write side, address and data taken in either order
    assign AXI_AWREADY_O = !aw_have_q && !bvalid_q;
    assign AXI_WREADY_O = !w_have_q && !bvalid_q;
    assign AXI_BVALID_O = bvalid_q;
    assign AXI_BRESP_O = bresp_q;
    assign wr_do = aw_have_q && w_have_q && !bvalid_q;
    // only lane 0 is checked, though the command word spans three bytes; other strobes are ignored
    assign wr_en = wr_do && lane0_q && mapped(awaddr_q);

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= BYTE_ZERO;
            wdata_q <= WORD_ZERO;
            lane0_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (AXI_AWVALID_I && AXI_AWREADY_O) begin
                aw_have_q <= 1'b1;
                awaddr_q <= AXI_AWADDR_I;
            end
            if (AXI_WVALID_I && AXI_WREADY_O) begin
                w_have_q <= 1'b1;
                wdata_q <= AXI_WDATA_I;
                lane0_q <= AXI_WSTRB_I[0];
            end
            if (wr_do) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && AXI_BREADY_I) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ---- bus slave: read side, one cycle to rvalid
    assign AXI_ARREADY_O = !rvalid_q;
    assign AXI_RVALID_O = rvalid_q;
    assign AXI_RDATA_O = rdata_q;
    assign AXI_RRESP_O = rresp_q;

    always_comb begin
        stat_w = WORD_ZERO;
        stat_w[ST_C] = c_q;
        stat_w[ST_DC] = dc_q;
        stat_w[ST_Z] = z_q;
        stat_w[ST_TO] = to_q;
        stat_w[ST_PWR] = pwr_q;
        stat_w[ST_SLP] = (state_q == ST_SLEEP);
        stat_w[ST_BUSY] = (state_q == ST_TBL);
        cmd_w = WORD_ZERO;
        cmd_w[CMD_OP_LSB +: OP_W] = op_q;
        cmd_w[CMD_DEST_BIT] = dest_q;
        cmd_w[CMD_FA_LSB +: FA_W] = fa_q;
        cmd_w[CMD_LIT_LSB +: 8] = lit_q;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            rvalid_q <= 1'b0;
            rdata_q <= WORD_ZERO;
            rresp_q <= RESP_OKAY;
        end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
            rvalid_q <= 1'b1;
            rresp_q <= mapped(AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= WORD_ZERO;
            if (AXI_ARADDR_I == A_CMD) begin
                rdata_q <= cmd_w;
            end else if (AXI_ARADDR_I == A_ACC) begin
                rdata_q[7:0] <= acc_q;
            end else if (AXI_ARADDR_I == A_STATUS) begin
                rdata_q <= stat_w;
            end else if (AXI_ARADDR_I == A_FADDR) begin
                rdata_q[FA_W-1:0] <= swfa_q;
            end else if (AXI_ARADDR_I == A_FDATA) begin
                rdata_q[7:0] <= file_q[swfa_q];
            end else if (AXI_ARADDR_I == A_PC) begin
                rdata_q[7:0] <= pc_q;
            end else if (AXI_ARADDR_I == A_WDT) begin
                rdata_q[7:0] <= wdt_q;
                rdata_q[WDT_PRE_LSB +: 8] <= pre_q;
            end
        end else if (rvalid_q && AXI_RREADY_I) begin
            rvalid_q <= 1'b0;
        end
    end

    // ---- command latch; a write to the command word issues one instruction
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            go_q <= 1'b0;
            op_q <= OP_NOP;
            dest_q <= 1'b0;
            fa_q <= '0;
            lit_q <= BYTE_ZERO;
        end else begin
            go_q <= wr_en && (awaddr_q == A_CMD);
            if (wr_en && (awaddr_q == A_CMD)) begin
                op_q <= aal_op_t'(wdata_q[CMD_OP_LSB +: OP_W]);
                dest_q <= wdata_q[CMD_DEST_BIT];
                fa_q <= wdata_q[CMD_FA_LSB +: FA_W];
                lit_q <= wdata_q[CMD_LIT_LSB +: 8];
            end
        end
    end

    // issued while busy or asleep the instruction is simply dropped
    assign ex = go_q && (state_q == ST_RUN);
    assign fval = file_q[fa_q];
    // literal select decoded here so no loop runs through the alu
    assign opnd = (op_q == OP_SUBL || op_q == OP_XORL) ? lit_q : fval;
    assign tbl_out = tbl_q[pc_q[TB_W-1:0]];
    assign to_acc = ex && alu_wr && (alu_lit || !dest_q); // [RQ3] [RQ6] [RQ11]
    assign to_file = ex && alu_wr && !alu_lit && dest_q; // [RQ3]
    assign sleep_go = ex && (op_q == OP_SLEEP);
    assign wake = wr_en && (awaddr_q == A_WAKE);

    aal_alu u_alu (
        .op_i(op_q),
        .acc_i(acc_q),
        .opnd_i(opnd),
        .c_i(c_q),
        .res_o(alu_res),
        .c_o(alu_c),
        .dc_o(alu_dc),
        .z_o(alu_z),
        .wr_o(alu_wr),
        .lit_o(alu_lit),
        .upd_c_o(upd_c),
        .upd_dc_o(upd_dc),
        .upd_z_o(upd_z)
    );

    // ---- accumulator; instruction results win over software writes
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            acc_q <= BYTE_ZERO;
        end else if (to_acc) begin
            acc_q <= alu_res;
        end else if (state_q == ST_TBL) begin
            acc_q <= tbl_out; // [RQ13]
        end else if (wr_en && (awaddr_q == A_ACC)) begin
            acc_q <= wdata_q[7:0];
        end
    end

    // ---- arithmetic flags
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            c_q <= 1'b0;
            dc_q <= 1'b0;
            z_q <= 1'b0;
        end else if (ex) begin
            if (upd_c) begin
                c_q <= alu_c; // [RQ1] [RQ2] [RQ5]
            end
            if (upd_dc) begin
                dc_q <= alu_dc; // [RQ5]
            end
            if (upd_z) begin
                z_q <= alu_z; // [RQ14]
            end
        end else if (wr_en && (awaddr_q == A_STATUS)) begin
            c_q <= wdata_q[ST_C];
            dc_q <= wdata_q[ST_DC];
            z_q <= wdata_q[ST_Z];
        end
    end

    // ---- power flags; entering sleep outranks a watchdog timeout
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            to_q <= 1'b1;
            pwr_q <= 1'b1;
        end else if (sleep_go) begin
            to_q <= 1'b1; // [RQ7]
            pwr_q <= 1'b0; // [RQ7]
        end else if (wdt_ovf) begin
            to_q <= 1'b0;
        end
    end

    // ---- file registers and constant table; storage needs no reset
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            swfa_q <= '0;
        end else if (wr_en && (awaddr_q == A_FADDR)) begin
            swfa_q <= wdata_q[FA_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (to_file) begin
            file_q[fa_q] <= alu_res; // [RQ3]
        end else if (wr_en && (awaddr_q == A_FDATA)) begin
            file_q[swfa_q] <= wdata_q[7:0];
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (wr_en && (awaddr_q == A_TBL)) begin
            tbl_q[wdata_q[TBL_IDX_LSB +: TB_W]] <= wdata_q[TBL_VAL_LSB +: 8];
        end
    end

    // ---- sequencer: program counter, table jump and sleep
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_q <= ST_RUN;
            pc_q <= BYTE_ZERO;
            ret_q <= BYTE_ZERO;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (ex && (op_q == OP_ADDPC)) begin
                        ret_q <= pc_q + PC_STEP;
                        pc_q <= pc_q + PC_STEP + acc_q; // [RQ13]
                        state_q <= ST_TBL;
                    end else if (ex) begin
                        pc_q <= pc_q + PC_STEP;
                        if (sleep_go) begin
                            state_q <= ST_SLEEP; // [RQ9]
                        end
                    end else if (wr_en && (awaddr_q == A_PC)) begin
                        pc_q <= wdata_q[7:0];
                    end
                end
                ST_TBL: begin
                    pc_q <= ret_q; // [RQ13]
                    state_q <= ST_RUN;
                end
                ST_SLEEP: begin
                    // only the watchdog or an explicit wake ends sleep
                    if (wake || wdt_ovf) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    assign SLEEP_O = (state_q == ST_SLEEP); // [RQ9]

    // ---- watchdog: divider tick, prescaler, counter
    assign tick = (div_q == DIV_LAST);
    assign wdt_ovf = tick && (&pre_q) && (&wdt_q);

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || sleep_go) begin
            pre_q <= BYTE_ZERO; // [RQ8]
            wdt_q <= BYTE_ZERO; // [RQ8]
        end else if (tick) begin
            pre_q <= pre_q + PC_STEP;
            if (&pre_q) begin
                wdt_q <= wdt_q + PC_STEP;
            end
        end
    end

    // ---- checks
    default clocking dc_cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    logic [3:0] acc_lo, opnd_lo;
    assign acc_lo = acc_q[3:0];
    assign opnd_lo = opnd[3:0];

    a_rot_right: assert property (ex && op_q == OP_ROTR |-> // [RQ1]
        alu_res == {c_q, fval[7:1]} ##1 c_q == $past(fval[0]))
        else $error("rotate right result or carry wrong");
    a_rot_left: assert property (ex && op_q == OP_ROTL |-> // [RQ2]
        alu_res == {fval[6:0], c_q} ##1 c_q == $past(fval[7]))
        else $error("rotate left result or carry wrong");
    a_dest_acc: assert property (ex && alu_wr && !alu_lit && !dest_q // [RQ3]
        |=> acc_q == $past(alu_res) && file_q[$past(fa_q)] == $past(fval))
        else $error("destination 0 did not go to accumulator");
    a_dest_file: assert property (to_file |=> // [RQ3]
        $stable(acc_q) && file_q[$past(fa_q)] == $past(alu_res))
        else $error("destination 1 did not go to file");
    a_sub_file: assert property (ex && op_q == OP_SUBF |-> // [RQ4]
        alu_res == 8'(fval - acc_q))
        else $error("file minus accumulator wrong");
    a_sub_flags: assert property (ex && (op_q == OP_SUBF || op_q == OP_SUBL) // [RQ5]
        |=> c_q == ($past(acc_q) <= $past(opnd)) && dc_q == ($past(acc_lo) <= $past(opnd_lo)))
        else $error("subtract carry flags wrong");
    a_sub_lit: assert property (ex && op_q == OP_SUBL |=> // [RQ6]
        acc_q == 8'($past(lit_q) - $past(acc_q)))
        else $error("literal minus accumulator wrong");
    a_sleep_flags: assert property (sleep_go |=> to_q && !pwr_q) // [RQ7]
        else $error("sleep power flags wrong");
    a_sleep_wdt: assert property (sleep_go |=> wdt_q == BYTE_ZERO && pre_q == BYTE_ZERO) // [RQ8]
        else $error("sleep left watchdog running");
    a_sleep_halt: assert property (sleep_go |=> SLEEP_O ##1 // [RQ9]
        (SLEEP_O || $past(wake) || $past(wdt_ovf)) && $stable(pc_q))
        else $error("core not halted after sleep");
    a_swap_keep: assert property (ex && op_q == OP_SWAPN |-> // [RQ10]
        alu_res == {fval[3:0], fval[7:4]} ##1 $stable({c_q, dc_q, z_q}))
        else $error("nibble exchange wrong");
    a_xor_lit: assert property (ex && op_q == OP_XORL |=> // [RQ11]
        acc_q == ($past(acc_q) ^ $past(lit_q)) && $stable({c_q, dc_q}))
        else $error("xor literal wrong");
    a_xor_file: assert property (ex && op_q == OP_XORF |-> // [RQ12]
        alu_res == (acc_q ^ fval) ##1 $stable({c_q, dc_q}))
        else $error("xor file wrong");
    a_table_jump: assert property (ex && op_q == OP_ADDPC |=> // [RQ13]
        state_q == ST_TBL ##1 state_q == ST_RUN && acc_q == $past(tbl_out) &&
        pc_q == $past(ret_q))
        else $error("table jump did not return constant");
    a_zero_flag: assert property (ex && upd_z |=> z_q == ($past(alu_res) == BYTE_ZERO)) // [RQ14]
        else $error("zero flag wrong");
endmodule : aal_core
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the accumulator alu core over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import aal_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic awr, wr_rdy, bv, arr, rv, slp;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdat, v, ra, rf, rs;
    logic [3:0] ws = 4'h0;
    logic [1:0] br, rr, rsp;
    int fail_count = 0;
    int checked = 0;
    aal_core #(.WDT_TICK(2)) uut (
        .REF_CLK_I(clk), .RST_I(rst),
        .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa),
        .AXI_WVALID_I(wv), .AXI_WREADY_O(wr_rdy), .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws),
        .AXI_BVALID_O(bv), .AXI_BREADY_I(bry), .AXI_BRESP_O(br),
        .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara),
        .AXI_RVALID_O(rv), .AXI_RREADY_I(rry), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr),
        .SLEEP_O(slp)
    );
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic summarize();
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // address and data offered together, each dropped once its own ready is seen
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ga, gw;
        ga = 1'b0;
        gw = 1'b0;
        @(posedge clk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; ws <= 4'hF; bry <= 1'b1;
        forever begin
            @(posedge clk);
            if (bv === 1'b1) begin
                r = br;
                break;
            end
            if (!ga && awr === 1'b1) begin
                ga = 1'b1;
                awv <= 1'b0;
            end
            if (!gw && wr_rdy === 1'b1) begin
                gw = 1'b1;
                wv <= 1'b0;
            end
        end
        bry <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic g;
        g = 1'b0;
        @(posedge clk);
        arv <= 1'b1; ara <= a; rry <= 1'b1;
        forever begin
            @(posedge clk);
            if (rv === 1'b1) begin
                d = rdat;
                r = rr;
                break;
            end
            if (!g && arr === 1'b1) begin
                g = 1'b1;
                arv <= 1'b0;
            end
        end
        rry <= 1'b0;
    endtask : axr
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, rsp);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        axr(a, d, rsp);
    endtask : rd
    // preload file 5, accumulator and flags, issue one instruction, read back all three
    task automatic tc(input aal_op_t op, input logic d, input logic [7:0] lit, input logic [7:0] acc,
                      input logic [7:0] fv, input logic [2:0] st, input logic [7:0] ea,
                      input logic [7:0] ef, input logic [2:0] es);
        wr(A_FADDR, 32'h0000_0005);
        wr(A_FDATA, {24'h00_0000, fv});
        wr(A_ACC, {24'h00_0000, acc});
        wr(A_STATUS, {29'h0000_0000, st});
        wr(A_CMD, {8'h00, lit, 1'b0, 7'h05, 3'h0, d, op});
        rd(A_ACC, ra);
        rd(A_FDATA, rf);
        rd(A_STATUS, rs);
        chk("acc", ra, {24'h00_0000, ea});
        chk("file", rf, {24'h00_0000, ef});
        chk("flags", rs & 32'h0000_0007, {29'h0000_0000, es});
    endtask : tc
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(A_ACC, v);
        chk("acc reset", v, 32'h0000_0000);
        rd(A_STATUS, v);
        chk("status reset", v, 32'h0000_0018);
        axw(8'h30, 32'h0000_00FF, rsp);
        chk("unmapped bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        axr(8'h30, v, rsp);
        chk("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        chk("unmapped rdata", v, 32'h0000_0000);
        tc(OP_ROTR, 1'b0, 8'h00, 8'h00, 8'hE6, 3'h0, 8'h73, 8'hE6, 3'h0);
        tc(OP_ROTR, 1'b1, 8'h00, 8'h11, 8'h01, 3'h5, 8'h11, 8'h80, 3'h5);
        tc(OP_ROTL, 1'b0, 8'h00, 8'h00, 8'hE6, 3'h0, 8'hCC, 8'hE6, 3'h1);
        tc(OP_ROTL, 1'b1, 8'h00, 8'h00, 8'h40, 3'h1, 8'h00, 8'h81, 3'h0);
        tc(OP_SUBF, 1'b0, 8'h00, 8'h02, 8'h03, 3'h4, 8'h01, 8'h03, 3'h3);
        tc(OP_SUBF, 1'b1, 8'h00, 8'h02, 8'h02, 3'h0, 8'h02, 8'h00, 3'h7);
        tc(OP_SUBF, 1'b0, 8'h00, 8'h02, 8'h01, 3'h7, 8'hFF, 8'h01, 3'h0);
        tc(OP_SUBF, 1'b0, 8'h00, 8'h01, 8'h10, 3'h0, 8'h0F, 8'h10, 3'h1);
        tc(OP_SUBF, 1'b0, 8'h00, 8'h10, 8'h0F, 3'h0, 8'hFF, 8'h0F, 3'h2);
        tc(OP_SUBL, 1'b1, 8'h10, 8'h01, 8'h33, 3'h0, 8'h0F, 8'h33, 3'h1);
        tc(OP_SUBL, 1'b0, 8'h05, 8'h05, 8'h33, 3'h0, 8'h00, 8'h33, 3'h7);
        tc(OP_SWAPN, 1'b1, 8'h00, 8'h00, 8'hA5, 3'h7, 8'h00, 8'h5A, 3'h7);
        tc(OP_SWAPN, 1'b0, 8'h00, 8'hFF, 8'h3C, 3'h0, 8'hC3, 8'h3C, 3'h0);
        tc(OP_XORL, 1'b0, 8'hAA, 8'hAA, 8'h12, 3'h3, 8'h00, 8'h12, 3'h7);
        tc(OP_XORL, 1'b1, 8'h0F, 8'hF0, 8'h12, 3'h7, 8'hFF, 8'h12, 3'h3);
        tc(OP_XORF, 1'b1, 8'h00, 8'hF0, 8'h0F, 3'h4, 8'hF0, 8'hFF, 3'h0);
        tc(OP_XORF, 1'b0, 8'h00, 8'h55, 8'h55, 3'h3, 8'h00, 8'h55, 3'h7);
        tc(OP_ADDF, 1'b1, 8'h00, 8'h01, 8'hFF, 3'h0, 8'h01, 8'h00, 3'h7);
        wr(A_TBL, 32'h0000_5C03);
        wr(A_PC, 32'h0000_0010);
        wr(A_ACC, 32'h0000_0002);
        wr(A_CMD, {28'h000_0000, OP_ADDPC});
        rd(A_ACC, v);
        chk("table constant", v, 32'h0000_005C);
        rd(A_PC, v);
        chk("return pc", v, 32'h0000_0011);
        // counter steps once per 512 cycles at the shortened tick
        repeat (1200) @(posedge clk);
        rd(A_WDT, v);
        chk("wdt running", {31'h0, v[7:0] != 8'h00}, 32'h0000_0001);
        wr(A_CMD, {28'h000_0000, OP_SLEEP});
        rd(A_STATUS, v);
        chk("sleep status", v & 32'h0000_0038, 32'h0000_0028);
        chk("sleep pin", {31'h0, slp}, 32'h0000_0001);
        rd(A_WDT, v);
        chk("wdt cleared", {24'h00_0000, v[7:0]}, 32'h0000_0000);
        chk("prescaler cleared", {31'h0, v[15:8] < 8'h10}, 32'h0000_0001);
        // an instruction issued while asleep must be dropped
        wr(A_CMD, {8'h00, 8'hFF, 12'h000, OP_XORL});
        wr(A_WAKE, 32'h0000_0001);
        rd(A_STATUS, v);
        chk("awake status", v & 32'h0000_0020, 32'h0000_0000);
        chk("awake pin", {31'h0, slp}, 32'h0000_0000);
        rd(A_ACC, v);
        chk("acc held asleep", v, 32'h0000_005C);
        summarize();
    end
endmodule : testbench
`default_nettype wire
